// ===== hw/tpwm_defs.svh
// Purpose: Named constants for the ten-bit modulator block
// Assumes: Registers are 8 bits wide on a plain strobe port
// Notes:   Offsets are word indices on the register port
`ifndef TPWM_DEFS_SVH
`define TPWM_DEFS_SVH

`define TPWM_NCH          3
`define TPWM_AW           4
// Register offsets
`define TPWM_OFF_PERIOD   4'h0
`define TPWM_OFF_TBCTRL   4'h1
`define TPWM_OFF_COUNT    4'h2
`define TPWM_OFF_FLAGS    4'h3
`define TPWM_OFF_CH_BASE  4'h4
`define TPWM_CH_STRIDE    4'h4
`define TPWM_SUB_CTRL     2'h0
`define TPWM_SUB_DCH      2'h1
`define TPWM_SUB_DCL      2'h2
// Channel control fields
`define TPWM_CTL_EN       7
`define TPWM_CTL_OUT      5
`define TPWM_CTL_INV      4
// Timebase control fields
`define TPWM_TB_ON        7
`define TPWM_TB_PS_HI     6
`define TPWM_TB_PS_LO     4
`define TPWM_TB_POST_HI   3
`define TPWM_TB_POST_LO   0
// Reset values
`define TPWM_RST_PERIOD   8'hff
`define TPWM_RST_BYTE     8'h00
`define TPWM_RST_DUTY     10'h000

`endif

// ===== hw/tpwm_pkg.sv
// Purpose: Shared types for the ten-bit modulator block
// Assumes: Constants come from tpwm_defs.svh
// Notes:   Types only
`include "tpwm_defs.svh"
package tpwm_pkg;
  typedef logic [7:0]       tpwm_byte_t;
  typedef logic [9:0]       tpwm_duty_t;
  typedef logic [`TPWM_AW-1:0] tpwm_addr_t;
endpackage

// ===== hw/tpwm_tb_if.sv
// Purpose: Carries shared timebase state to the channel comparators
// Assumes: One driver module, many readers
// Notes:   Wrap is high while the counter sits at the period match; the counter clears when run is also high
`timescale 1ns/10ps
`default_nettype none
interface tpwm_tb_if;
  logic [9:0] base;   // Counter and two sub-count bits
  logic [7:0] period; // Shared period value
  logic       wrap;   // Period match rollover pulse
  logic       run;    // Counting this cycle
  modport src (output base, output period, output wrap, output run);
  modport dst (input base, input period, input wrap, input run);
endinterface
`default_nettype wire

// ===== hw/tpwm_channel.sv
// Purpose: One modulator channel with shadowed duty and comparator
// Assumes: Duty registers are held by the top
// Notes:   Output level comes from a flip-flop
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_defs.svh"
module tpwm_channel (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  // Shared timebase
  tpwm_tb_if.dst                   tb,
  // Channel settings
  input  wire tpwm_pkg::tpwm_duty_t duty_i,
  input  wire logic                enable_i,
  input  wire logic                invert_i,
  // Output
  output logic                     level_o
);
  import tpwm_pkg::*;

  typedef struct packed {
    tpwm_duty_t shadow;
    logic       raw;
  } tpwm_ch_state_t;

  tpwm_ch_state_t st;
  tpwm_ch_state_t next_st;

  // Shadow reload, set at wrap, clear on match
  always_comb begin
    next_st = st;
    if (tb.run) begin
      if (tb.wrap) begin
        next_st.shadow = duty_i;
        next_st.raw    = enable_i && (duty_i != `TPWM_RST_DUTY);
      end else if (!enable_i) begin
        next_st.raw = 1'b0;
      end else if ((tb.base + 10'h001 == st.shadow) && (st.shadow[9:2] < tb.period)) begin
        // Clear as the base steps onto the duty value, so high time is duty ticks
        next_st.raw = 1'b0;
      end
    end else if (!enable_i) begin
      next_st.raw = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= '{shadow: `TPWM_RST_DUTY, raw: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.raw ^ invert_i;

  a_zero_duty_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (tb.run && tb.wrap && duty_i == 10'h000) |=> !st.raw)
    else $error("Zero duty set the output");
  a_wrap_sets: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (tb.run && tb.wrap && enable_i && duty_i != 10'h000) |=> st.raw)
    else $error("Output not set at counter clear");
  a_disabled_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !enable_i |=> !st.raw)
    else $error("Disabled channel went active");
  a_polarity_map: assert property (@(posedge core_clk_i) disable iff (srst_i)
    level_o == (st.raw != invert_i))
    else $error("Polarity mapping wrong");
endmodule // tpwm_channel
`default_nettype wire

// ===== hw/tpwm_timebase.sv
// Purpose: Shared 8-bit counter with prescaled two-bit sub-count
// Assumes: Prescale code selects 1,4,16,64,... ratios
// Notes:   Postscaler only drives the match flag event
`timescale 1ns/10ps
`default_nettype none
module tpwm_timebase (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  // Settings
  input  wire tpwm_pkg::tpwm_byte_t period_i,
  input  wire logic              on_i,
  input  wire logic [2:0]        prescale_i,
  input  wire logic [3:0]        postscale_i,
  input  wire logic              sleep_i,
  // Count write
  input  wire logic              cnt_we_i,
  input  wire tpwm_pkg::tpwm_byte_t cnt_wdata_i,
  // Shared timebase
  tpwm_tb_if.src                 tb,
  // Postscaled match event
  output logic                   post_evt_o
);
  import tpwm_pkg::*;

  typedef struct packed {
    logic [13:0] pre;
    logic [9:0]  base;
    logic [3:0]  post;
  } tpwm_tb_state_t;

  tpwm_tb_state_t st;
  tpwm_tb_state_t next_st;
  logic           tick;
  logic           match;

  // Prescale terminal count check
  function automatic logic pre_done(input logic [13:0] p, input logic [2:0] sel);
    logic [13:0] lim;
    lim = 14'h0001 << {sel[2:0], 1'b0};
    // Reaching or passing the limit ends the count, so a smaller ratio never stalls
    pre_done = (p >= lim - 14'h0001);
  endfunction

  assign tick  = on_i && !sleep_i && pre_done(st.pre, prescale_i);
  assign match = (st.base[9:2] == period_i) && (st.base[1:0] == 2'h3);

  // Counter advance and period wrap
  always_comb begin
    next_st = st;
    if (on_i && !sleep_i) begin
      next_st.pre = tick ? 14'h0000 : st.pre + 14'h0001;
    end
    if (tick) begin
      if (match) begin
        next_st.base = 10'h000;
        next_st.post = (st.post >= postscale_i) ? 4'h0 : st.post + 4'h1;
      end else begin
        next_st.base = st.base + 10'h001;
      end
    end
    if (cnt_we_i) begin
      next_st.base = {cnt_wdata_i, 2'h0};
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tb.base    = st.base;
  assign tb.period  = period_i;
  assign tb.wrap    = match;
  assign tb.run     = tick;
  assign post_evt_o = tick && match && (st.post >= postscale_i);

  a_sleep_freeze: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (sleep_i && !cnt_we_i) |=> $stable(st.base))
    else $error("Counter moved in sleep");
  a_wrap_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (tick && match && !cnt_we_i) |=> st.base == 10'h000)
    else $error("Counter not cleared at period match");
endmodule // tpwm_timebase
`default_nettype wire

// ===== hw/tpwm_top.sv
// Purpose: Ten-bit modulator with shared timebase and three channels
// Assumes: Register port is 8-bit, read data one cycle after strobe
// Notes:   Channel c control at 4+4c, duty high 5+4c, duty low 6+4c
//
// What this block does
// - Outputs go active when counter clears, unless duty is zero
// - Output inactive when base equals duty
// - Duty at or above period never clears
// - Duty registers shadowed, reloaded at match
// - Period match clears counter, sets, reloads
// - Polarity bit inverts channel waveform
// - Period is (period+1) times 4 times prescale
// - Postscaler never affects the waveform
// - Ten-bit base from counter plus sub-count
// - Duty writes anytime outside sleep, shadow drives compare
// - One period shared, independent duties
// - Resolution log2 of 4(period+1) bits
// - Sleep freezes counter and all state except read data
// - Reset restores registers, pins to input
// - Polarity one gives active-low output
// - Control read returns present output level
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tpwm_defs.svh"
module tpwm_top (
  // Clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  // Register port
  input  wire tpwm_pkg::tpwm_addr_t      addr_i,
  input  wire tpwm_pkg::tpwm_byte_t      wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output tpwm_pkg::tpwm_byte_t           rdata_o,
  // System state
  input  wire logic                      sleep_i,
  input  wire logic [`TPWM_NCH-1:0]      pin_direction_bit_i,
  // Outputs
  output logic [`TPWM_NCH-1:0]           pin_out_o,
  output logic [`TPWM_NCH-1:0]           pin_oe_o,
  output logic [`TPWM_NCH-1:0]           periph_out_o,
  output logic                           timebase_match_flag_o
);
  import tpwm_pkg::*;

  typedef struct packed {
    tpwm_byte_t                 period_match_value;
    tpwm_byte_t                 timebase_control;
    logic                       match_flag;
    logic [`TPWM_NCH-1:0]       ch_en;
    logic [`TPWM_NCH-1:0]       ch_inv;
    logic [`TPWM_NCH-1:0][7:0]  duty_high_byte;
    logic [`TPWM_NCH-1:0][1:0]  duty_low_pair;
    tpwm_byte_t                 rdata;
  } tpwm_top_state_t;

  tpwm_top_state_t       st;
  tpwm_top_state_t       next_st;
  logic [`TPWM_NCH-1:0]  level;
  logic                  post_evt;
  tpwm_tb_if             tb_bus ();

  // Channel index decode of a register address
  function automatic logic [1:0] ch_of(input tpwm_addr_t a);
    tpwm_addr_t d;
    d = a - `TPWM_OFF_CH_BASE;
    ch_of = d[3:2];
  endfunction

  // Shared timebase
  tpwm_timebase u_tb (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .period_i    (st.period_match_value),
    .on_i        (st.timebase_control[`TPWM_TB_ON]),
    .prescale_i  (st.timebase_control[`TPWM_TB_PS_HI:`TPWM_TB_PS_LO]),
    .postscale_i (st.timebase_control[`TPWM_TB_POST_HI:`TPWM_TB_POST_LO]),
    .sleep_i     (sleep_i),
    .cnt_we_i    (wr_i && !sleep_i && addr_i == `TPWM_OFF_COUNT),
    .cnt_wdata_i (wdata_i),
    .tb          (tb_bus.src),
    .post_evt_o  (post_evt)
  );

  // One comparator per channel sharing one period
  genvar g;
  generate
    for (g = 0; g < `TPWM_NCH; g++) begin : g_ch
      tpwm_channel u_ch (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .tb         (tb_bus.dst),
        .duty_i     ({st.duty_high_byte[g], st.duty_low_pair[g]}),
        .enable_i   (st.ch_en[g]),
        .invert_i   (st.ch_inv[g]),
        .level_o    (level[g])
      );
    end
  endgenerate

  // Register writes, flag update and read mux
  always_comb begin
    logic [1:0] c;
    logic [1:0] sub;
    c = ch_of(addr_i);
    sub = addr_i[1:0];
    next_st = st;
    next_st.rdata = `TPWM_RST_BYTE;
    if (wr_i && !sleep_i) begin
      unique case (addr_i)
        `TPWM_OFF_PERIOD: next_st.period_match_value = wdata_i;
        `TPWM_OFF_TBCTRL: next_st.timebase_control = wdata_i;
        `TPWM_OFF_FLAGS:  next_st.match_flag = wdata_i[0];
        default: begin
          if (addr_i >= `TPWM_OFF_CH_BASE && c < 2'(`TPWM_NCH)) begin
            if (sub == `TPWM_SUB_CTRL) begin
              next_st.ch_en[c]  = wdata_i[`TPWM_CTL_EN];
              next_st.ch_inv[c] = wdata_i[`TPWM_CTL_INV];
            end else if (sub == `TPWM_SUB_DCH) begin
              next_st.duty_high_byte[c] = wdata_i;
            end else if (sub == `TPWM_SUB_DCL) begin
              next_st.duty_low_pair[c] = wdata_i[7:6];
            end
          end
        end
      endcase
    end
    // Hardware set wins over software clear
    if (post_evt) begin
      next_st.match_flag = 1'b1;
    end
    if (rd_i) begin
      unique case (addr_i)
        `TPWM_OFF_PERIOD: next_st.rdata = st.period_match_value;
        `TPWM_OFF_TBCTRL: next_st.rdata = st.timebase_control;
        `TPWM_OFF_COUNT:  next_st.rdata = tb_bus.base[9:2];
        `TPWM_OFF_FLAGS:  next_st.rdata = {7'h00, st.match_flag};
        default: begin
          if (addr_i >= `TPWM_OFF_CH_BASE && c < 2'(`TPWM_NCH)) begin
            if (sub == `TPWM_SUB_CTRL) begin
              next_st.rdata[`TPWM_CTL_EN]  = st.ch_en[c];
              next_st.rdata[`TPWM_CTL_OUT] = level[c];
              next_st.rdata[`TPWM_CTL_INV] = st.ch_inv[c];
            end else if (sub == `TPWM_SUB_DCH) begin
              next_st.rdata = st.duty_high_byte[c];
            end else if (sub == `TPWM_SUB_DCL) begin
              next_st.rdata = {st.duty_low_pair[c], 6'h00};
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      next_reset: begin
        st <= '0;
        st.period_match_value <= `TPWM_RST_PERIOD;
      end
    end else begin
      st <= next_st;
    end
  end

  // Pin path and internal consumers
  assign periph_out_o          = level;
  assign pin_out_o             = level;
  assign pin_oe_o              = srst_i ? '0 : ~pin_direction_bit_i;
  assign timebase_match_flag_o = st.match_flag;
  assign rdata_o               = st.rdata;

  a_flag_on_event: assert property (@(posedge core_clk_i) disable iff (srst_i)
    post_evt |=> st.match_flag)
    else $error("Match event lost");
  a_duty_write_held: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (wr_i && !sleep_i && addr_i == `TPWM_OFF_CH_BASE + `TPWM_SUB_DCH)
      |=> st.duty_high_byte[0] == $past(wdata_i))
    else $error("Duty write not stored");
  a_sleep_regs: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (sleep_i && !post_evt) |=> $stable(st.period_match_value) && $stable(st.ch_en))
    else $error("Registers changed in sleep");
endmodule // tpwm_top
`default_nettype wire

// ===== verification/tpwm_pin_model.sv
// Purpose: Port pad model fed by the modulator pin path
// Assumes: Released pad has a weak pull-up
// Notes:   Peripherals read periph_out directly
`timescale 1ns/10ps
`default_nettype none
module tpwm_pin_model (
  // Modulator side
  input  wire logic [2:0] pin_out_i,
  input  wire logic [2:0] pin_oe_i,
  // Pad side
  output logic [2:0]      pad_o
);
  // Driven pad follows the waveform, released pad pulls high
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : 1'b1;
    end
  end
endmodule // tpwm_pin_model
`default_nettype wire

// ===== verification/tpwm_top_test.sv
// Purpose: Self-checking bench for the ten-bit modulator
// Assumes: Period 7 gives 32 cycles at 1:1 prescale
// Notes:   High time is counted over whole periods
`timescale 1ns/10ps
`default_nettype none
module tpwm_top_test;
  import tpwm_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0;
  tpwm_addr_t  addr = 4'h0;
  tpwm_byte_t  wdata = 8'h00, rdata, rv, r2;
  logic [2:0]  dir = 3'h7, pin_out, pin_oe, periph, pad, ps;
  logic        flag;
  logic [15:0] cnt [3];
  int          errors = 0, checks_done = 0;

  // Clock
  always #5 clk = ~clk;

  // Block and pad model
  tpwm_top DUT (.core_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .sleep_i(sleep), .pin_direction_bit_i(dir), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .periph_out_o(periph), .timebase_match_flag_o(flag));
  tpwm_pin_model pads (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pad_o(pad));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bw(input tpwm_addr_t a, input tpwm_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic br(input tpwm_addr_t a, output tpwm_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chan(input int c, input tpwm_byte_t ctl, input tpwm_duty_t d);
    bw(4'(5 + 4 * c), d[9:2]);
    bw(4'(6 + 4 * c), {d[1:0], 6'h00});
    bw(4'(4 + 4 * c), ctl);
  endtask
  task automatic high(input int n);
    cnt = '{16'h0000, 16'h0000, 16'h0000};
    repeat (n) begin
      @(negedge clk);
      for (int i = 0; i < 3; i++) cnt[i] = cnt[i] + pin_out[i];
    end
  endtask
  task automatic wait_lvl(input logic v);
    int k;
    for (k = 0; k < 600 && pin_out[0] !== v; k++) @(negedge clk);
    chk(k < 600, 16'h0001);
  endtask
  task automatic summarize;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset values, unmapped place, pins released
  task automatic t_reset;
    @(posedge clk);
    srst <= 1'b1;
    dir <= 3'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(pin_oe, 16'h0000);
    chk(pin_out, 16'h0000);
    @(posedge clk);
    srst <= 1'b0;
    br(4'h0, rv);
    chk(rv, 16'h00ff);
    chk(pin_oe, 16'h0007);
    br(4'h4, rv);
    chk(rv, 16'h0000);
    bw(4'h7, 8'h55);
    br(4'h7, rv);
    chk(rv, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_duty;
    bw(4'h0, 8'h07);
    chan(0, 8'h80, 10'h00a);
    chan(1, 8'h80, 10'h014);
    chan(2, 8'h80, 10'h000);
    bw(4'h3, 8'h00);
    bw(4'h1, 8'h80);
    repeat (64) @(negedge clk);
    high(128);
    chk(cnt[0], 16'h0028);
    chk(cnt[1], 16'h0050);
    chk(cnt[2], 16'h0000);
    $display("test duty done");
  endtask
  task automatic t_mode;
    bw(4'h4, 8'h00);
    bw(4'h8, 8'h90);
    chan(2, 8'h80, 10'h01c);
    repeat (64) @(negedge clk);
    high(128);
    chk(cnt[0], 16'h0000);
    chk(cnt[1], 16'h0030);
    chk(cnt[2], 16'h0080);
    br(4'hc, rv);
    chk(rv, 16'h00a0);
    $display("test mode done");
  endtask
  task automatic t_scale;
    bw(4'h4, 8'h80);
    bw(4'h1, 8'h9f);
    repeat (300) @(negedge clk);
    high(256);
    chk(cnt[0], 16'h0050);
    chk(cnt[1], 16'h0060);
    bw(4'h1, 8'h8f);
    repeat (64) @(negedge clk);
    high(128);
    chk(cnt[0], 16'h0028);
    $display("test scale done");
  endtask
  task automatic t_shadow;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    fork
      high(32);
      chan(0, 8'h80, 10'h00d);
    join
    chk(cnt[0], 16'h000a);
    high(32);
    chk(cnt[0], 16'h000d);
    $display("test shadow done");
  endtask
  task automatic t_sleep;
    @(posedge clk);
    sleep <= 1'b1;
    @(negedge clk);
    ps = pin_out;
    br(4'h2, rv);
    bw(4'h0, 8'h03);
    high(40);
    for (int i = 0; i < 3; i++) chk(cnt[i], ps[i] ? 16'h0028 : 16'h0000);
    br(4'h2, r2);
    chk(r2, rv);
    br(4'h0, r2);
    chk(r2, 16'h0007);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (64) @(negedge clk);
    high(128);
    chk(cnt[0], 16'h0034);
    $display("test sleep done");
  endtask
  task automatic t_pins;
    for (int d = 0; d < 8; d++) begin
      @(posedge clk);
      dir <= 3'(d);
      @(negedge clk);
      chk(pin_oe, {13'h0000, ~dir});
      chk(periph, pin_out);
      chk(pad, pin_out | dir);
    end
    $display("test pins done");
  endtask
  task automatic t_flag;
    int k;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    bw(4'h3, 8'h00);
    @(negedge clk);
    chk(flag, 16'h0000);
    bw(4'h1, 8'h80);
    for (k = 0; k < 600 && flag !== 1'b1; k++) @(negedge clk);
    chk(flag, 16'h0001);
    br(4'h3, rv);
    chk(rv[0], 16'h0001);
    bw(4'h2, 8'h05);
    br(4'h2, rv);
    chk(rv, 16'h0005);
    $display("test flag done");
  endtask

  // Main sequence
  initial begin
    t_reset;
    t_duty;
    t_mode;
    t_scale;
    t_shadow;
    t_sleep;
    t_pins;
    t_flag;
    t_reset;
    summarize;
  end

  // Watchdog
  initial begin
    #300000;
    errors++;
    summarize;
  end
endmodule // tpwm_top_test
`default_nettype wire
